// >>> src/cpsi_core.sv
// Program counter, return stack, shadow context and indirect pointer logic
`timescale 1ns/1ps
module cpsi_core
	import cpsi_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic op_valid_i,
	input wire cpsi_op_type op_i,
	input wire logic [5:0] instr_id_i,
	input wire logic [14:0] op_arg_i,
	input wire logic [7:0] w_i,
	input wire logic ptr_sel_i,
	input wire logic [7:0] ind_wdata_i,
	input wire logic [CPSI_CTX_W-1:0] ctx_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [13:0] pfm_rdata_i,
	input wire logic [7:0] dm_rdata_i,
	output logic [7:0] reg_rdata_o,
	output logic [14:0] pc_o,
	output logic busy_o,
	output logic illegal_o,
	output logic w_load_o,
	output logic [7:0] w_value_o,
	output logic ind_valid_o,
	output logic [7:0] ind_rdata_o,
	output logic ctx_restore_o,
	output logic [CPSI_CTX_W-1:0] ctx_o,
	output logic soft_reset_o,
	output logic [10:0] pfm_addr_o,
	output logic pfm_re_o,
	output logic pfm_hef_o,
	output logic [11:0] dm_addr_o,
	output logic dm_re_o,
	output logic dm_we_o,
	output logic [7:0] dm_wdata_o
);
	// Indirect access sequencer
	typedef enum logic [2:0] {
		ST_IDLE, ST_DM_STB, ST_DM_CAP, ST_PF_STB, ST_PF_CAP, ST_PF_XTRA
	} cpsi_state_type;

	cpsi_state_type state_reg, state_next;
	logic [14:0] pc_reg, pc_next;
	logic [15:0] ptr0_reg, ptr0_next, ptr1_reg, ptr1_next;
	logic [15:0] sh_ptr0_reg, sh_ptr0_next, sh_ptr1_reg, sh_ptr1_next;
	logic [CPSI_CTX_W-1:0] sh_ctx_reg, sh_ctx_next, ctx_reg, ctx_next;
	logic ovf_reg, ovf_next, unf_reg, unf_next, stkrst_en_reg, stkrst_en_next;
	logic soft_rst_reg, soft_rst_next;
	logic [7:0] rdata_reg, rdata_next, res_reg, res_next, wval_reg, wval_next;
	logic busy_reg, busy_next, illegal_reg, illegal_next, wload_reg, wload_next;
	logic ind_valid_reg, ind_valid_next, restore_reg, restore_next;
	logic [10:0] pfm_addr_reg, pfm_addr_next;
	logic pfm_re_reg, pfm_re_next, hef_reg, hef_next;
	logic [11:0] dm_addr_reg, dm_addr_next;
	logic dm_re_reg, dm_re_next, dm_we_reg, dm_we_next;
	logic [7:0] dm_wdata_reg, dm_wdata_next;
	// Command decode helpers
	logic take, take_ok, is_illegal;
	logic [15:0] ptr_sel;
	// Selected pointer folded into the implemented program space
	logic [14:0] ptr_pc;
	logic [14:0] pc_inc;
	// Stack hookup
	logic push, pop, stk_ovf, stk_unf;
	logic [14:0] push_data, stk_top;
	logic [CPSI_SP_W-1:0] stk_level;

	// Return stack
	cpsi_stack u_stack (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.clear_i(soft_rst_reg),
		.push_i(push),
		.pop_i(pop),
		.push_data_i(push_data),
		.top_o(stk_top),
		.level_o(stk_level),
		.overflow_o(stk_ovf),
		.underflow_o(stk_unf)
	);

	// Next-state computation for the whole block
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		ptr0_next = ptr0_reg;
		ptr1_next = ptr1_reg;
		sh_ptr0_next = sh_ptr0_reg;
		sh_ptr1_next = sh_ptr1_reg;
		sh_ctx_next = sh_ctx_reg;
		ctx_next = ctx_reg;
		ovf_next = ovf_reg;
		unf_next = unf_reg;
		stkrst_en_next = stkrst_en_reg;
		res_next = res_reg;
		wval_next = wval_reg;
		pfm_addr_next = pfm_addr_reg;
		dm_addr_next = dm_addr_reg;
		dm_wdata_next = dm_wdata_reg;
		// Pulses default low
		soft_rst_next = 1'b0;
		illegal_next = 1'b0;
		wload_next = 1'b0;
		ind_valid_next = 1'b0;
		restore_next = 1'b0;
		pfm_re_next = 1'b0;
		hef_next = 1'b0;
		dm_re_next = 1'b0;
		dm_we_next = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_data = '0;
		// Commands are only taken while no indirect access is in flight
		take = op_valid_i && (state_reg == ST_IDLE) && !soft_rst_reg;
		is_illegal = (instr_id_i >= CPSI_NUM_INSTR); // R1
		take_ok = take && !is_illegal;
		ptr_sel = ptr_sel_i ? ptr1_reg : ptr0_reg; // R6
		ptr_pc = cpsi_wrap_pc(ptr_sel[14:0]); // R10
		pc_inc = cpsi_wrap_pc(pc_reg + 15'h0001); // R9 R10
		if (take && is_illegal) begin
			// Unknown opcode acts as a no-op but is reported
			illegal_next = 1'b1; // R1
			pc_next = pc_inc;
		end else if (take_ok) begin
			unique case (op_i)
				CPSI_OP_NEXT: begin
					pc_next = pc_inc;
				end
				CPSI_OP_GOTO: begin
					pc_next = cpsi_wrap_pc(op_arg_i); // R10
				end
				CPSI_OP_CALL: begin
					push = 1'b1; // R17
					push_data = pc_inc;
					pc_next = cpsi_wrap_pc(op_arg_i);
				end
				CPSI_OP_CALL_VIA_WORKING: begin
					// Target high bits from the latch, low byte from working register
					push = 1'b1; // R17
					push_data = pc_inc;
					pc_next = cpsi_wrap_pc({op_arg_i[14:8], w_i});
				end
				CPSI_OP_RETURN: begin
					pop = 1'b1; // R17
					pc_next = cpsi_wrap_pc(stk_top);
				end
				CPSI_OP_RETURN_WITH_LITERAL: begin
					pop = 1'b1; // R16
					pc_next = cpsi_wrap_pc(stk_top);
					wload_next = 1'b1; // R16
					wval_next = op_arg_i[7:0];
				end
				CPSI_OP_RETFIE: begin
					// Context and pointers come back from the shadows
					pop = 1'b1; // R17
					pc_next = cpsi_wrap_pc(stk_top);
					ctx_next = sh_ctx_reg; // R2
					restore_next = 1'b1;
					ptr0_next = sh_ptr0_reg;
					ptr1_next = sh_ptr1_reg;
				end
				CPSI_OP_BRW: begin
					// Table index jump used by literal tables
					pc_next = cpsi_wrap_pc(pc_inc + {7'h00, w_i}); // R16
				end
				CPSI_OP_IRQ: begin
					// The interrupted instruction is resumed on return
					push = 1'b1; // R17
					push_data = pc_reg;
					pc_next = CPSI_IRQ_VEC; // R11
					sh_ctx_next = ctx_i; // R2
					sh_ptr0_next = ptr0_reg;
					sh_ptr1_next = ptr1_reg;
				end
				CPSI_OP_IND_RD: begin
					pc_next = pc_inc;
					if (ptr_sel[CPSI_PTR_PFM_BIT]) begin
						// Program memory target, wrapped to implemented words
						pfm_addr_next = ptr_pc[10:0]; // R13
						pfm_re_next = 1'b1;
						hef_next = (ptr_pc >= CPSI_HEF_LO) && (ptr_pc <= CPSI_HEF_HI); // R12
						state_next = ST_PF_STB; // R7
					end else begin
						dm_addr_next = cpsi_lin_map(ptr_sel); // R8
						dm_re_next = 1'b1;
						state_next = ST_DM_STB;
					end
				end
				CPSI_OP_IND_WR: begin
					pc_next = pc_inc;
					// Program memory is read-only through the pointer path
					if (!ptr_sel[CPSI_PTR_PFM_BIT]) begin // R15
						dm_addr_next = cpsi_lin_map(ptr_sel); // R8
						dm_we_next = 1'b1;
						dm_wdata_next = ind_wdata_i;
					end
				end
				default: begin
					pc_next = pc_inc;
				end
			endcase
		end
		// Read sequencer; memories answer the cycle after the strobe
		unique case (state_reg)
			ST_IDLE: begin
			end
			ST_DM_STB: begin
				state_next = ST_DM_CAP;
			end
			ST_DM_CAP: begin
				res_next = dm_rdata_i;
				ind_valid_next = 1'b1;
				state_next = ST_IDLE;
			end
			ST_PF_STB: begin
				state_next = ST_PF_CAP;
			end
			ST_PF_CAP: begin
				res_next = pfm_rdata_i[7:0]; // R14
				state_next = ST_PF_XTRA;
			end
			ST_PF_XTRA: begin
				// The additional instruction cycle for program fetches
				ind_valid_next = 1'b1; // R7
				state_next = ST_IDLE;
			end
			// Unused codes fall back to idle
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Software port writes; a zero written to a flag clears it
		if (reg_we_i) begin
			unique case (reg_addr_i)
				CPSI_OFS_PTR0_LO: ptr0_next[7:0] = reg_wdata_i;
				CPSI_OFS_PTR0_HI: ptr0_next[15:8] = reg_wdata_i;
				CPSI_OFS_PTR1_LO: ptr1_next[7:0] = reg_wdata_i;
				CPSI_OFS_PTR1_HI: ptr1_next[15:8] = reg_wdata_i;
				CPSI_OFS_POWER_CONTROL_STATUS: begin
					ovf_next = ovf_reg & reg_wdata_i[CPSI_POWER_CONTROL_STATUS_OVF_BIT];
					unf_next = unf_reg & reg_wdata_i[CPSI_POWER_CONTROL_STATUS_UNF_BIT];
				end
				CPSI_OFS_CTRL: stkrst_en_next = reg_wdata_i[CPSI_CTRL_STKRST_BIT];
				default: begin
				end
			endcase
		end
		// Hardware set wins over a simultaneous software clear
		if (stk_ovf) begin
			ovf_next = 1'b1; // R4
		end
		if (stk_unf) begin
			unf_next = 1'b1; // R4
		end
		if ((stk_ovf || stk_unf) && stkrst_en_reg) begin
			soft_rst_next = 1'b1; // R5
		end
		// Device reset from a stack error restarts at the reset vector
		if (soft_rst_reg) begin
			pc_next = CPSI_RESET_VEC; // R5 R11
			state_next = ST_IDLE;
		end
		// Register read data, one cycle after the strobe
		rdata_next = 8'h00;
		if (reg_re_i) begin
			unique case (reg_addr_i)
				CPSI_OFS_PTR0_LO: rdata_next = ptr0_reg[7:0];
				CPSI_OFS_PTR0_HI: rdata_next = ptr0_reg[15:8];
				CPSI_OFS_PTR1_LO: rdata_next = ptr1_reg[7:0];
				CPSI_OFS_PTR1_HI: rdata_next = ptr1_reg[15:8];
				CPSI_OFS_POWER_CONTROL_STATUS: rdata_next = {ovf_reg, unf_reg, 6'h00};
				CPSI_OFS_CTRL: rdata_next = {7'h00, stkrst_en_reg};
				CPSI_OFS_PC_LO: rdata_next = pc_reg[7:0];
				CPSI_OFS_PC_HI: rdata_next = {1'b0, pc_reg[14:8]};
				CPSI_OFS_STKPTR: rdata_next = {3'h0, stk_level};
				default: rdata_next = 8'h00;
			endcase
		end
		busy_next = (state_next != ST_IDLE);
	end

	// State registers; all outputs leave straight from here
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= ST_IDLE;
			pc_reg <= CPSI_RESET_VEC; // R11
			ptr0_reg <= CPSI_PTR_RST;
			ptr1_reg <= CPSI_PTR_RST;
			sh_ptr0_reg <= CPSI_PTR_RST;
			sh_ptr1_reg <= CPSI_PTR_RST;
			sh_ctx_reg <= '0;
			ctx_reg <= '0;
			ovf_reg <= 1'b0;
			unf_reg <= 1'b0;
			stkrst_en_reg <= CPSI_STKRST_RST;
			soft_rst_reg <= 1'b0;
			rdata_reg <= 8'h00;
			res_reg <= 8'h00;
			wval_reg <= 8'h00;
			busy_reg <= 1'b0;
			illegal_reg <= 1'b0;
			wload_reg <= 1'b0;
			ind_valid_reg <= 1'b0;
			restore_reg <= 1'b0;
			pfm_addr_reg <= '0;
			pfm_re_reg <= 1'b0;
			hef_reg <= 1'b0;
			dm_addr_reg <= '0;
			dm_re_reg <= 1'b0;
			dm_we_reg <= 1'b0;
			dm_wdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			ptr0_reg <= ptr0_next;
			ptr1_reg <= ptr1_next;
			sh_ptr0_reg <= sh_ptr0_next;
			sh_ptr1_reg <= sh_ptr1_next;
			sh_ctx_reg <= sh_ctx_next;
			ctx_reg <= ctx_next;
			ovf_reg <= ovf_next;
			unf_reg <= unf_next;
			stkrst_en_reg <= stkrst_en_next;
			soft_rst_reg <= soft_rst_next;
			rdata_reg <= rdata_next;
			res_reg <= res_next;
			wval_reg <= wval_next;
			busy_reg <= busy_next;
			illegal_reg <= illegal_next;
			wload_reg <= wload_next;
			ind_valid_reg <= ind_valid_next;
			restore_reg <= restore_next;
			pfm_addr_reg <= pfm_addr_next;
			pfm_re_reg <= pfm_re_next;
			hef_reg <= hef_next;
			dm_addr_reg <= dm_addr_next;
			dm_re_reg <= dm_re_next;
			dm_we_reg <= dm_we_next;
			dm_wdata_reg <= dm_wdata_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign pc_o = pc_reg;
	assign busy_o = busy_reg;
	assign illegal_o = illegal_reg;
	assign w_load_o = wload_reg;
	assign w_value_o = wval_reg;
	assign ind_valid_o = ind_valid_reg;
	assign ind_rdata_o = res_reg;
	assign ctx_restore_o = restore_reg;
	assign ctx_o = ctx_reg;
	assign soft_reset_o = soft_rst_reg;
	assign pfm_addr_o = pfm_addr_reg;
	assign pfm_re_o = pfm_re_reg;
	assign pfm_hef_o = hef_reg;
	assign dm_addr_o = dm_addr_reg;
	assign dm_re_o = dm_re_reg;
	assign dm_we_o = dm_we_reg;
	assign dm_wdata_o = dm_wdata_reg;

	// Checks on sequencing behaviour
	property p_reset_vec;
		@(posedge clk_i) srst_i |=> (pc_o == CPSI_RESET_VEC);
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector"); // R11

	property p_irq_vec;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_IRQ) |=> (pc_o == CPSI_IRQ_VEC);
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("irq did not vector"); // R11

	property p_pc_wrap;
		@(posedge clk_i) disable iff (srst_i) (pc_o[14:11] == 4'h0);
	endproperty
	a_pc_wrap: assert property (p_pc_wrap) else $error("pc left implemented space"); // R10

	property p_pfm_extra;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_IND_RD && ptr_sel[CPSI_PTR_PFM_BIT])
		|=> (!ind_valid_o && busy_o) [*3] ##1 ind_valid_o;
	endproperty
	a_pfm_extra: assert property (p_pfm_extra) else $error("program read timing"); // R7

	property p_dm_read;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_IND_RD && !ptr_sel[CPSI_PTR_PFM_BIT])
		|=> dm_re_o ##1 !ind_valid_o ##1 ind_valid_o;
	endproperty
	a_dm_read: assert property (p_dm_read) else $error("data read timing"); // R13

	property p_no_pfm_write;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_IND_WR && ptr_sel[CPSI_PTR_PFM_BIT]) |=> !dm_we_o;
	endproperty
	a_no_pfm_write: assert property (p_no_pfm_write) else $error("write leaked"); // R15

	property p_low_byte;
		@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_PF_CAP) |-> ##2 (ind_valid_o && ind_rdata_o == $past(pfm_rdata_i[7:0], 2));
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("program byte wrong"); // R14

	property p_stack_flags;
		@(posedge clk_i) disable iff (srst_i)
		(stk_ovf |=> ovf_reg) and (stk_unf |=> unf_reg);
	endproperty
	a_stack_flags: assert property (p_stack_flags) else $error("stack flag not set"); // R4

	property p_stack_reset;
		@(posedge clk_i) disable iff (srst_i)
		((stk_ovf || stk_unf) && stkrst_en_reg) |=> soft_reset_o ##1 (pc_o == CPSI_RESET_VEC);
	endproperty
	a_stack_reset: assert property (p_stack_reset) else $error("no stack reset"); // R5

	property p_return_with_literal;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_RETURN_WITH_LITERAL)
		|=> (w_load_o && w_value_o == $past(op_arg_i[7:0]) && pc_o == $past(cpsi_wrap_pc(stk_top)));
	endproperty
	a_return_with_literal: assert property (p_return_with_literal) else $error("literal return wrong"); // R16

	property p_call;
		@(posedge clk_i) disable iff (srst_i)
		(take_ok && op_i == CPSI_OP_CALL && stk_level < 5'h10)
		|=> (pc_o == $past(cpsi_wrap_pc(op_arg_i)) && stk_level == $past(stk_level) + 5'h01);
	endproperty
	a_call: assert property (p_call) else $error("call did not push"); // R17

	c_pfm_read: cover property (@(posedge clk_i) disable iff (srst_i) state_reg == ST_PF_XTRA);
	c_overflow: cover property (@(posedge clk_i) disable iff (srst_i) stk_ovf);
	c_retfie: cover property (@(posedge clk_i) disable iff (srst_i) restore_reg);
endmodule

// >>> src/cpsi_pkg.sv
// Constants, types and helper functions for the CPU program-memory, stack and pointer block
// Summary of operation
// R1 - Core decodes exactly 49 distinct instructions
// R2 - Interrupt saves context to shadows, return restores
// R3 - Return stack: 16 entries of 15 bits
// R4 - Push overflow / empty pop set status flags
// R5 - Stack error may trigger a device reset
// R6 - Two 16-bit pointers reach data and program
// R7 - Program-memory indirect access takes one extra cycle
// R8 - Pointers give linear view of general RAM
// R9 - Program counter is 15 bits, 32K space
// R10 - Addresses above 07FFh wrap into implemented memory
// R11 - Reset starts at 0000h, interrupt at 0004h
// R12 - High-endurance region is 0780h to 07FFh
// R13 - Pointer high bit 7 selects program memory
// R14 - Program read loads only low eight bits
// R15 - Indirect writes never modify program memory
// R16 - Return-with-literal returns and loads working register
// R17 - Calls and interrupts push, returns pop
package cpsi_pkg;
	// Instruction count decoded by the core
	localparam logic [5:0] CPSI_NUM_INSTR = 6'h31;
	// Program counter and implemented space
	localparam int CPSI_PC_W = 15;
	localparam logic [14:0] CPSI_PC_MASK = 15'h07FF;
	localparam logic [14:0] CPSI_RESET_VEC = 15'h0000;
	localparam logic [14:0] CPSI_IRQ_VEC = 15'h0004;
	localparam logic [14:0] CPSI_HEF_LO = 15'h0780;
	localparam logic [14:0] CPSI_HEF_HI = 15'h07FF;
	// Return stack geometry
	localparam int CPSI_STACK_DEPTH = 16;
	localparam int CPSI_SP_W = 5;
	// Pointer layout: bit 7 of the high byte selects program memory
	localparam int CPSI_PTR_PFM_BIT = 15;
	// Linear general RAM window
	localparam logic [15:0] CPSI_LIN_BASE = 16'h2000;
	localparam logic [15:0] CPSI_LIN_TOP = 16'h29AF;
	localparam logic [11:0] CPSI_GPR_PER_BANK = 12'h050;
	localparam logic [6:0] CPSI_GPR_OFS = 7'h20;
	// Register port offsets
	localparam logic [3:0] CPSI_OFS_PTR0_LO = 4'h0;
	localparam logic [3:0] CPSI_OFS_PTR0_HI = 4'h1;
	localparam logic [3:0] CPSI_OFS_PTR1_LO = 4'h2;
	localparam logic [3:0] CPSI_OFS_PTR1_HI = 4'h3;
	localparam logic [3:0] CPSI_OFS_POWER_CONTROL_STATUS = 4'h4;
	localparam logic [3:0] CPSI_OFS_CTRL = 4'h5;
	localparam logic [3:0] CPSI_OFS_PC_LO = 4'h6;
	localparam logic [3:0] CPSI_OFS_PC_HI = 4'h7;
	localparam logic [3:0] CPSI_OFS_STKPTR = 4'h8;
	// Field positions
	localparam int CPSI_POWER_CONTROL_STATUS_OVF_BIT = 7;
	localparam int CPSI_POWER_CONTROL_STATUS_UNF_BIT = 6;
	localparam int CPSI_CTRL_STKRST_BIT = 0;
	// Reset values
	localparam logic [15:0] CPSI_PTR_RST = 16'h0000;
	localparam logic CPSI_STKRST_RST = 1'b1;
	// Width of the saved core context
	localparam int CPSI_CTX_W = 32;

	// Core sequencing commands
	typedef enum logic [3:0] {
		CPSI_OP_NEXT, CPSI_OP_GOTO, CPSI_OP_CALL, CPSI_OP_CALL_VIA_WORKING, CPSI_OP_RETURN,
		CPSI_OP_RETURN_WITH_LITERAL, CPSI_OP_RETFIE, CPSI_OP_BRW, CPSI_OP_IRQ, CPSI_OP_IND_RD,
		CPSI_OP_IND_WR
	} cpsi_op_type;

	// Fold any architectural address into the implemented space
	function automatic logic [14:0] cpsi_wrap_pc(input logic [14:0] a);
		return a & CPSI_PC_MASK;
	endfunction

	// Map a data-side pointer to a 12-bit data address, linear window included
	function automatic logic [11:0] cpsi_lin_map(input logic [15:0] p);
		logic [11:0] off;
		logic [11:0] bank;
		logic [11:0] low;
		off = p[11:0] - CPSI_LIN_BASE[11:0];
		bank = off / CPSI_GPR_PER_BANK;
		low = off % CPSI_GPR_PER_BANK;
		if (p >= CPSI_LIN_BASE && p <= CPSI_LIN_TOP) begin
			return {bank[4:0], CPSI_GPR_OFS + low[6:0]};
		end
		return p[11:0];
	endfunction
endpackage

// >>> src/cpsi_stack.sv
// Hardware return-address stack with overflow and underflow detection
`timescale 1ns/1ps
module cpsi_stack
	import cpsi_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [14:0] push_data_i,
	output logic [14:0] top_o,
	output logic [CPSI_SP_W-1:0] level_o,
	output logic overflow_o,
	output logic underflow_o
);
	// Storage for return addresses
	logic [14:0] mem [CPSI_STACK_DEPTH]; // R3
	// Entry count, 0 to 16
	logic [CPSI_SP_W-1:0] sp_reg;
	logic [CPSI_SP_W-1:0] sp_next;
	logic full;
	logic empty;

	// Occupancy and pop value
	always_comb begin
		full = (sp_reg == CPSI_SP_W'(CPSI_STACK_DEPTH));
		empty = (sp_reg == '0);
		// Empty pop returns the reset vector rather than stale data
		top_o = empty ? CPSI_RESET_VEC : mem[4'(sp_reg - 1'b1)];
		overflow_o = push_i && full;
		underflow_o = pop_i && empty;
		level_o = sp_reg;
		sp_next = sp_reg;
		if (clear_i) begin
			sp_next = '0;
		end else if (push_i && !full) begin
			sp_next = sp_reg + 1'b1;
		end else if (pop_i && !empty) begin
			sp_next = sp_reg - 1'b1;
		end
	end

	// Pointer register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sp_reg <= '0;
		end else begin
			sp_reg <= sp_next;
		end
	end

	// Entry write; a push into a full stack is dropped
	always_ff @(posedge clk_i) begin
		if (push_i && !full && !clear_i) begin
			mem[4'(sp_reg)] <= push_data_i;
		end
	end
endmodule

// >>> testbench/cpsi_mem_model.sv
// Behavioural flash and data memory facing the core block
`timescale 1ns/1ps
module cpsi_mem_model (
	input wire logic clk_i,
	input wire logic [10:0] pfm_addr_i,
	input wire logic pfm_re_i,
	input wire logic [11:0] dm_addr_i,
	input wire logic dm_re_i,
	input wire logic dm_we_i,
	input wire logic [7:0] dm_wdata_i,
	output logic [13:0] pfm_rdata_o,
	output logic [7:0] dm_rdata_o
);
	// Data bytes, seeded with a pattern so every read has a known value
	logic [7:0] ram [4096];

	// Seed the data array
	initial begin
		pfm_rdata_o = 14'h0000;
		dm_rdata_o = 8'h00;
		for (int i = 0; i < 4096; i++)
			ram[i] = i[7:0] ^ 8'hA5;
	end

	// Answer one cycle after a strobe; the lines toggle otherwise
	// so a stale value never passes for fresh data
	always @(posedge clk_i) begin
		// Only data memory has a write path; flash content is fixed
		if (dm_we_i) begin
			ram[dm_addr_i] <= dm_wdata_i;
		end
		// Full 14-bit word; the core must strip it to a byte
		pfm_rdata_o <= pfm_re_i ? {3'h5, pfm_addr_i ^ 11'h155} : ~pfm_rdata_o;
		dm_rdata_o <= dm_re_i ? ram[dm_addr_i] : ~dm_rdata_o;
	end
endmodule

// >>> testbench/tb.sv
// Self-checking testbench for the program counter, stack and pointer core
`timescale 1ns/1ps
module tb
	import cpsi_pkg::*;
;
	// Stimulus
	logic clk_i = 1'b0, srst_i = 1'b1, op_valid_i = 1'b0, ptr_sel_i = 1'b0;
	cpsi_op_type op_i = CPSI_OP_NEXT;
	logic [5:0] instr_id_i = 6'h00;
	logic [14:0] op_arg_i = 15'h0000;
	logic [7:0] w_i = 8'h00, ind_wdata_i = 8'h00, reg_wdata_i = 8'h00;
	logic [31:0] ctx_i = 32'hCAFE_0123;
	logic [3:0] reg_addr_i = 4'h0;
	logic reg_we_i = 1'b0, reg_re_i = 1'b0;
	// Memory answers
	logic [13:0] pfm_rdata_i;
	logic [7:0] dm_rdata_i;
	// Observed outputs
	logic [7:0] reg_rdata_o, w_value_o, ind_rdata_o, dm_wdata_o;
	logic [14:0] pc_o;
	logic busy_o, illegal_o, w_load_o, ind_valid_o, ctx_restore_o, soft_reset_o;
	logic [31:0] ctx_o;
	logic [10:0] pfm_addr_o;
	logic pfm_re_o, pfm_hef_o, dm_re_o, dm_we_o;
	logic [11:0] dm_addr_o;
	int n_fail = 0, cmp_count = 0, n;

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	cpsi_core dut_u (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i), .op_i(op_i),
		.instr_id_i(instr_id_i), .op_arg_i(op_arg_i), .w_i(w_i), .ptr_sel_i(ptr_sel_i),
		.ind_wdata_i(ind_wdata_i), .ctx_i(ctx_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.pfm_rdata_i(pfm_rdata_i), .dm_rdata_i(dm_rdata_i), .reg_rdata_o(reg_rdata_o),
		.pc_o(pc_o), .busy_o(busy_o), .illegal_o(illegal_o), .w_load_o(w_load_o),
		.w_value_o(w_value_o), .ind_valid_o(ind_valid_o), .ind_rdata_o(ind_rdata_o),
		.ctx_restore_o(ctx_restore_o), .ctx_o(ctx_o), .soft_reset_o(soft_reset_o),
		.pfm_addr_o(pfm_addr_o), .pfm_re_o(pfm_re_o), .pfm_hef_o(pfm_hef_o),
		.dm_addr_o(dm_addr_o), .dm_re_o(dm_re_o), .dm_we_o(dm_we_o), .dm_wdata_o(dm_wdata_o));

	cpsi_mem_model mem_u (.clk_i(clk_i), .pfm_addr_i(pfm_addr_o), .pfm_re_i(pfm_re_o),
		.dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o), .dm_we_i(dm_we_o), .dm_wdata_i(dm_wdata_o),
		.pfm_rdata_o(pfm_rdata_i), .dm_rdata_o(dm_rdata_i));

	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One command; returns just after the edge that answers it
	task cmd(input cpsi_op_type op, input logic [14:0] arg, input logic [7:0] w,
		input logic [5:0] id);
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_i <= op;
		op_arg_i <= arg;
		w_i <= w;
		instr_id_i <= id;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
	endtask

	// Register read, data judged in the single cycle it stands
	task rr(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask

	// Register write
	task rw(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	// Pointer select and write byte for the next indirect command
	task sel(input logic s, input logic [7:0] d);
		@(posedge clk_i);
		ptr_sel_i <= s;
		ind_wdata_i <= d;
	endtask

	// Cycles until the indirect result; bounded so a hang ends the run
	task wait_valid;
		n = 0;
		while (ind_valid_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 10) begin
			n_fail++;
			report_and_stop;
		end
	endtask

	// Values straight after reset
	task t_reset;
		chk(pc_o, 15'h0000);
		rr(CPSI_OFS_POWER_CONTROL_STATUS, 8'h00);
		rr(CPSI_OFS_CTRL, 8'h01);
		rr(CPSI_OFS_STKPTR, 8'h00);
		rr(4'hF, 8'h00);
	endtask

	// Every sequencing command except the indirect ones, interrupt vector, wrap and context save
	task t_flow;
		cmd(CPSI_OP_GOTO, 15'h0123, 8'h00, 6'h00);
		chk(pc_o, 15'h0123);
		cmd(CPSI_OP_NEXT, 15'h0000, 8'h00, 6'h31);
		chk(illegal_o, 1'b1);
		cmd(CPSI_OP_NEXT, 15'h0000, 8'h00, 6'h30);
		chk(illegal_o, 1'b0);
		chk(pc_o, 15'h0125);
		cmd(CPSI_OP_IRQ, 15'h0000, 8'h00, 6'h00);
		chk(pc_o, 15'h0004);
		ctx_i <= 32'h0000_0000;
		cmd(CPSI_OP_RETFIE, 15'h0000, 8'h00, 6'h00);
		chk(pc_o, 15'h0125);
		chk(ctx_restore_o, 1'b1);
		chk(ctx_o, 32'hCAFE_0123);
		cmd(CPSI_OP_CALL, 15'h7ABC, 8'h00, 6'h00);
		chk(pc_o, 15'h02BC);
		cmd(CPSI_OP_CALL_VIA_WORKING, 15'h0100, 8'h80, 6'h00);
		chk(pc_o, 15'h0180);
		cmd(CPSI_OP_RETURN, 15'h0000, 8'h00, 6'h00);
		chk(pc_o, 15'h02BD);
		cmd(CPSI_OP_BRW, 15'h0000, 8'h10, 6'h00);
		chk(pc_o, 15'h02CE);
		cmd(CPSI_OP_RETURN_WITH_LITERAL, 15'h003C, 8'h00, 6'h00);
		chk(pc_o, 15'h0126);
		chk(w_load_o, 1'b1);
		chk(w_value_o, 8'h3C);
		rr(CPSI_OFS_PC_HI, 8'h01);
	endtask

	// Fill the stack, overflow with reset, then underflow without it
	task t_stack;
		for (int i = 0; i < 16; i++)
			cmd(CPSI_OP_CALL, 15'(i), 8'h00, 6'h00);
		rr(CPSI_OFS_STKPTR, 8'h10);
		cmd(CPSI_OP_CALL, 15'h0055, 8'h00, 6'h00);
		chk(soft_reset_o, 1'b1);
		@(posedge clk_i);
		#1;
		chk(pc_o, 15'h0000);
		rr(CPSI_OFS_POWER_CONTROL_STATUS, 8'h80);
		rr(CPSI_OFS_STKPTR, 8'h00);
		rw(CPSI_OFS_POWER_CONTROL_STATUS, 8'h00);
		rw(CPSI_OFS_CTRL, 8'h00);
		cmd(CPSI_OP_RETURN, 15'h0000, 8'h00, 6'h00);
		chk(soft_reset_o, 1'b0);
		rr(CPSI_OFS_POWER_CONTROL_STATUS, 8'h40);
	endtask

	// Indirect reads of flash and linear RAM, and refused flash write
	task t_ind;
		rw(CPSI_OFS_PTR0_HI, 8'h87);
		rw(CPSI_OFS_PTR0_LO, 8'h90);
		rw(CPSI_OFS_PTR1_HI, 8'h20);
		rw(CPSI_OFS_PTR1_LO, 8'h50);
		rr(CPSI_OFS_PTR1_LO, 8'h50);
		sel(1'b0, 8'h3A);
		cmd(CPSI_OP_IND_RD, 15'h0000, 8'h00, 6'h00);
		chk(pfm_addr_o, 11'h790);
		chk(pfm_re_o, 1'b1);
		chk(pfm_hef_o, 1'b1);
		chk(busy_o, 1'b1);
		wait_valid;
		chk(n, 3);
		chk(ind_rdata_o, 8'hC5);
		sel(1'b1, 8'h3A);
		cmd(CPSI_OP_IND_RD, 15'h0000, 8'h00, 6'h00);
		chk(dm_addr_o, 12'h0A0);
		chk(dm_re_o, 1'b1);
		wait_valid;
		chk(n, 2);
		chk(ind_rdata_o, 8'h05);
		sel(1'b0, 8'h3A);
		cmd(CPSI_OP_IND_WR, 15'h0000, 8'h00, 6'h00);
		chk(dm_we_o, 1'b0);
		sel(1'b1, 8'h3A);
		cmd(CPSI_OP_IND_WR, 15'h0000, 8'h00, 6'h00);
		chk(dm_we_o, 1'b1);
		chk(dm_wdata_o, 8'h3A);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		t_reset;
		t_flow;
		t_stack;
		t_ind;
		report_and_stop;
	end
endmodule
